// ### shared/fllc_pkg.sv
`default_nettype none
package fllc_pkg;
    // Register byte addresses on the bus.
    localparam logic [7:0] ADDR_CTRL = 8'h24;
    localparam logic [7:0] ADDR_VAL = 8'h28;
    localparam logic [7:0] ADDR_MUL = 8'h2c;
    localparam logic [7:0] ADDR_SYNC = 8'h30;
    localparam logic [7:0] ADDR_STAT = 8'h38;
    localparam logic [7:0] ADDR_MASK = 8'h3c;

    // Loop control bit positions and reset value.
    localparam int CTRL_ENABLE = 1;
    localparam int CTRL_MODE = 2;
    localparam int CTRL_STABLE = 3;
    localparam int CTRL_LOSE_LOCK = 4;
    localparam int CTRL_ON_REQUEST = 7;
    localparam int CTRL_CHILL_OFF = 8;
    localparam int CTRL_QUICK_OFF = 9;
    localparam logic [15:0] CTRL_RESET = 16'h0080;
    localparam logic [15:0] CTRL_WMASK = 16'h039e;

    // Value and multiplier field positions.
    localparam int VAL_CYCLE_DIFFERENCE_LSB = 16;
    localparam int VAL_COARSE_LSB = 10;
    localparam int MUL_COARSE_STEP_LSB = 26;
    localparam int MUL_FINE_STEP_LSB = 16;
    localparam int SYNC_READ_REQUEST = 7;
    localparam logic [9:0] FINE_MID = 10'h200;
    localparam logic [15:0] FINE_TOL = 16'h0001;
    localparam logic [15:0] FINE_TOL_QUICK = 16'h0004;

    // Status bits: sticky events in 3:0, live state in 6:4.
    localparam int EV_READY = 0;
    localparam int EV_CLOCK = 1;
    localparam int EV_FLOCK = 2;
    localparam int EV_LOST = 3;
    localparam int ST_READY = 4;
    localparam int ST_CLOCK = 5;
    localparam int ST_FLOCK = 6;

    // Synchronisation delay of written settings.
    localparam int CLK_PERIOD_NS = 8;
    localparam int SYNC_TIME_NS = 32;
    localparam logic [3:0] SYNC_CYCLES = 4'((SYNC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    localparam logic [1:0] RESP_OK = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_COARSE = 2'b01,
        PH_FINE = 2'b10,
        PH_LOCKED = 2'b11
    } fllc_phase_t;
endpackage
`default_nettype wire

// ### core/fllc_step_limit.sv
`timescale 1ns/1ps
`default_nettype none
// Moves a calibration value one bounded step and saturates at its range ends.
module fllc_step_limit #(
    parameter int W = 6
) (
    // Present value and loop demand.
    input wire logic [W-1:0] cur,
    input wire logic [15:0] mag,
    input wire logic up,
    input wire logic [W-1:0] max_step,
    // Next value.
    output logic [W-1:0] nxt
);
    logic [15:0] step;
    logic [16:0] sum;

    // The step is the smaller of the error and the allowed maximum.
    always_comb begin
        step = (mag < 16'(max_step)) ? mag : 16'(max_step);
        sum = up ? 17'(cur) + 17'(step) : 17'(cur) - 17'(step);
        if (up) begin
            nxt = (|sum[16:W]) ? '1 : sum[W-1:0];
        end else begin
            nxt = sum[16] ? '0 : sum[W-1:0];
        end
    end
endmodule // fllc_step_limit
`default_nettype wire

// ### core/fllc_sync_delay.sv
`timescale 1ns/1ps
`default_nettype none
// Counts out the settling time of a written setting; a new start restarts it.
module fllc_sync_delay
    import fllc_pkg::*;
(
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Start and completion.
    input wire logic start,
    output logic busy,
    output logic done
);
    typedef struct packed {
        logic busy;
        logic done;
        logic [3:0] cnt;
    } fllc_sync_t;

    fllc_sync_t s_q;
    fllc_sync_t s_d;

    // Done is a single pulse after SYNC_CYCLES edges of busy.
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (start) begin
            s_d.busy = 1'b1;
            s_d.cnt = SYNC_CYCLES - 4'h1;
        end else if (s_q.busy) begin
            if (s_q.cnt == 4'h0) begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt - 4'h1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign busy = s_q.busy;
    assign done = s_q.done;
endmodule // fllc_sync_delay
`default_nettype wire

// ### core/fllc_loop_regs.sv
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module fllc_loop_regs
    import fllc_pkg::*;
(
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write channels.
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read channels.
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Loop measurement and system events.
    input wire logic ref_tick,
    input wire logic out_tick,
    input wire logic clk_request,
    input wire logic wake_stopped,
    // Oscillator control.
    output logic osc_run,
    output logic closed_loop,
    output logic [5:0] coarse_cal,
    output logic [9:0] fine_cal,
    output logic quick_lock_disable,
    output logic chill_cycle_disable,
    output logic loop_ready_flag,
    output logic irq
);
    import fllc_pkg::*;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic aw_have;
        logic w_have;
        logic [7:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [15:0] ctrl;
        logic [31:0] mul;
        logic osc_en;
        logic run;
        logic rd_pend;
        logic chill;
        logic prev_up;
        logic ready;
        fllc_phase_t phase;
        logic [5:0] coarse;
        logic [9:0] fine;
        logic [15:0] cycle_difference;
        logic [15:0] cnt;
        logic [31:0] snap;
        logic [3:0] stat;
        logic [3:0] mask;
        logic irq;
    } fllc_state_t;

    fllc_state_t s_q;
    fllc_state_t s_d;

    logic wr_go;
    logic sync_start;
    logic sync_busy;
    logic sync_done;
    logic [31:0] bmask;
    logic [31:0] wmerged;
    logic [3:0] ev;
    logic [3:0] clr;
    logic [15:0] meas;
    logic [15:0] cycle_difference_n;
    logic [15:0] mag;
    logic up;
    logic [15:0] tol;
    logic [5:0] coarse_nx;
    logic [9:0] fine_nx;
    logic [31:0] rd_mux;

    // Bounded coarse and fine steps.
    fllc_step_limit #(.W(6)) u_coarse_step (
        .cur(s_q.coarse),
        .mag(mag),
        .up(up),
        .max_step(s_q.mul[MUL_COARSE_STEP_LSB +: 6]),
        .nxt(coarse_nx)
    );

    fllc_step_limit #(.W(10)) u_fine_step (
        .cur(s_q.fine),
        .mag(mag),
        .up(up),
        .max_step(s_q.mul[MUL_FINE_STEP_LSB +: 10]),
        .nxt(fine_nx)
    );

    // One settling timer serves control, multiplier and read-request writes.
    fllc_sync_delay u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(sync_start),
        .busy(sync_busy),
        .done(sync_done)
    );

    // Byte-lane mask of the pending write and the merged write word.
    always_comb begin
        bmask = {{8{s_q.wstrb[3]}}, {8{s_q.wstrb[2]}}, {8{s_q.wstrb[1]}}, {8{s_q.wstrb[0]}}};
        wmerged = s_q.wdata & bmask;
    end

    // Measurement arithmetic for the period that ends on this reference tick.
    always_comb begin
        meas = s_q.cnt + 16'(out_tick);
        cycle_difference_n = s_q.mul[15:0] - meas;
        up = !cycle_difference_n[15];
        mag = cycle_difference_n[15] ? 16'(-cycle_difference_n) : cycle_difference_n;
        tol = s_q.ctrl[CTRL_QUICK_OFF] ? FINE_TOL : FINE_TOL_QUICK;
    end

    // Read data for the address offered on the read channel.
    always_comb begin
        rd_mux = '0;
        case (araddr)
            ADDR_CTRL: rd_mux = {16'h0000, s_q.ctrl};
            ADDR_VAL: begin
                // Closed loop shows the last requested snapshot.
                if (s_q.ctrl[CTRL_MODE]) begin
                    rd_mux = s_q.snap;
                end else begin
                    rd_mux = {s_q.cycle_difference, s_q.coarse, s_q.fine};
                end
            end
            ADDR_MUL: rd_mux = s_q.mul;
            ADDR_SYNC: rd_mux = '0;
            ADDR_STAT: begin
                rd_mux[3:0] = s_q.stat;
                rd_mux[ST_READY] = s_q.ready;
                rd_mux[ST_CLOCK] = (s_q.phase == PH_FINE) || (s_q.phase == PH_LOCKED);
                rd_mux[ST_FLOCK] = (s_q.phase == PH_LOCKED);
            end
            ADDR_MASK: rd_mux = {28'h0000000, s_q.mask};
            default: rd_mux = '0;
        endcase
    end

    // Next state of the whole block.
    always_comb begin
        s_d = s_q;
        ev = '0;
        clr = '0;
        sync_start = 1'b0;
        wr_go = s_q.aw_have && s_q.w_have && !s_q.bvalid;

        // Address and data are taken in either order and held until answered.
        if (awvalid && s_q.awready) begin
            s_d.aw_have = 1'b1;
            s_d.waddr = awaddr;
        end
        if (wvalid && s_q.wready) begin
            s_d.w_have = 1'b1;
            s_d.wdata = wdata;
            s_d.wstrb = wstrb;
        end
        if (bready && s_q.bvalid) begin
            s_d.bvalid = 1'b0;
        end

        // Register writes.
        if (wr_go) begin
            s_d.aw_have = 1'b0;
            s_d.w_have = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = RESP_OK;
            case (s_q.waddr)
                ADDR_CTRL: begin
                    // Takes effect in the register at once.
                    s_d.ctrl = (s_q.ctrl & ~(bmask[15:0] & CTRL_WMASK))
                        | (wmerged[15:0] & CTRL_WMASK);
                    sync_start = 1'b1;
                end
                ADDR_VAL: begin
                    // The loop owns the calibration in closed loop.
                    if (!s_q.ctrl[CTRL_MODE]) begin
                        {s_d.coarse, s_d.fine} = ({s_q.coarse, s_q.fine} & ~bmask[15:0])
                            | wmerged[15:0];
                    end
                end
                ADDR_MUL: begin
                    s_d.mul = (s_q.mul & ~bmask) | wmerged;
                    s_d.fine = FINE_MID;
                    s_d.phase = s_q.ctrl[CTRL_MODE] ? PH_COARSE : PH_IDLE;
                    ev[EV_LOST] = (s_q.phase == PH_FINE) || (s_q.phase == PH_LOCKED);
                    sync_start = 1'b1;
                end
                ADDR_SYNC: begin
                    if (bmask[SYNC_READ_REQUEST] && s_q.wdata[SYNC_READ_REQUEST]) begin
                        s_d.rd_pend = 1'b1;
                        sync_start = 1'b1;
                    end
                end
                ADDR_STAT: clr = wmerged[3:0];
                ADDR_MASK: s_d.mask = wmerged[3:0] | (s_q.mask & ~bmask[3:0]);
                default: s_d.bresp = RESP_SLVERR;
            endcase
        end

        // Reads answer one cycle after the address is taken.
        if (rready && s_q.rvalid) begin
            s_d.rvalid = 1'b0;
        end
        if (arvalid && s_q.arready) begin
            s_d.rvalid = 1'b1;
            s_d.rdata = rd_mux;
            s_d.rresp = (araddr == ADDR_CTRL || araddr == ADDR_VAL || araddr == ADDR_MUL
                || araddr == ADDR_SYNC || araddr == ADDR_STAT || araddr == ADDR_MASK)
                ? RESP_OK : RESP_SLVERR;
        end
        s_d.awready = !s_d.aw_have && !s_d.bvalid;
        s_d.wready = !s_d.w_have && !s_d.bvalid;
        s_d.arready = !s_d.rvalid;

        // Settled writes pass only the enable bit to the oscillator; a pending read request snapshots.
        if (sync_done) begin
            s_d.osc_en = s_q.ctrl[CTRL_ENABLE];
            ev[EV_READY] = 1'b1;
            if (s_q.rd_pend) begin
                s_d.snap = {s_q.cycle_difference, s_q.coarse, s_q.fine};
                s_d.rd_pend = 1'b0;
            end
        end
        // Ready stays low from the write until its settling ends.
        s_d.ready = !(sync_start || (sync_busy && !sync_done));

        // On request the oscillator runs only while a consumer asks.
        s_d.run = s_q.osc_en && (!s_q.ctrl[CTRL_ON_REQUEST] || clk_request);

        // Closed-loop regulation once per reference period.
        if (s_q.run && s_q.ctrl[CTRL_MODE]) begin
            if (ref_tick) begin
                s_d.cnt = '0;
                s_d.cycle_difference = cycle_difference_n;
                if (s_q.chill) begin
                    // The period after a change is skipped so the oscillator settles.
                    s_d.chill = 1'b0;
                end else begin
                    s_d.chill = !s_q.ctrl[CTRL_CHILL_OFF];
                    unique case (s_q.phase)
                        PH_IDLE: begin
                            s_d.phase = PH_COARSE;
                            s_d.prev_up = up;
                            s_d.chill = 1'b0;
                        end
                        PH_COARSE: begin
                            // A reversal of the error sign means coarse is bracketed.
                            if (up != s_q.prev_up || mag == 16'h0000) begin
                                s_d.phase = PH_FINE;
                                ev[EV_CLOCK] = 1'b1;
                            end else begin
                                s_d.coarse = coarse_nx;
                            end
                            s_d.prev_up = up;
                        end
                        PH_FINE: begin
                            if (mag <= tol) begin
                                s_d.phase = PH_LOCKED;
                                ev[EV_FLOCK] = 1'b1;
                            end else begin
                                s_d.fine = fine_nx;
                            end
                        end
                        PH_LOCKED: begin
                            // Stable mode holds fine once locked.
                            if (!s_q.ctrl[CTRL_STABLE]) begin
                                s_d.fine = fine_nx;
                            end
                        end
                    endcase
                end
            end else if (out_tick && s_q.cnt != 16'hffff) begin
                s_d.cnt = s_q.cnt + 16'h0001;
            end
        end

        // A multiplier write's fine and phase reset beat a regulation step in the same cycle; a coarse step still lands.
        if (wr_go && s_q.waddr == ADDR_MUL) begin
            s_d.fine = FINE_MID;
            s_d.phase = s_q.ctrl[CTRL_MODE] ? PH_COARSE : PH_IDLE;
        end

        // A wake with the clock stopped drops locks when so configured.
        if (wake_stopped && s_q.ctrl[CTRL_LOSE_LOCK] && s_q.phase != PH_IDLE) begin
            s_d.phase = s_q.ctrl[CTRL_MODE] ? PH_COARSE : PH_IDLE;
            ev[EV_LOST] = 1'b1;
        end

        // A new event wins over a clear in the same cycle.
        s_d.stat = (s_q.stat & ~clr) | ev;
        s_d.irq = |(s_d.stat & s_q.mask);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
            s_q.ctrl <= CTRL_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register.
    assign awready = s_q.awready;
    assign wready = s_q.wready;
    assign bvalid = s_q.bvalid;
    assign bresp = s_q.bresp;
    assign arready = s_q.arready;
    assign rvalid = s_q.rvalid;
    assign rdata = s_q.rdata;
    assign rresp = s_q.rresp;
    assign osc_run = s_q.run;
    assign closed_loop = s_q.ctrl[CTRL_MODE];
    assign coarse_cal = s_q.coarse;
    assign fine_cal = s_q.fine;
    assign quick_lock_disable = s_q.ctrl[CTRL_QUICK_OFF];
    assign chill_cycle_disable = s_q.ctrl[CTRL_CHILL_OFF];
    assign loop_ready_flag = s_q.ready;
    assign irq = s_q.irq;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Checks on the block's own behaviour.
    a_ready_low_pending: assert property (
        wr_go && s_q.waddr == ADDR_CTRL |=> !loop_ready_flag [*4])
        else $error("ready flag high during synchronised write");
    a_enable_readback: assert property (
        wr_go && s_q.waddr == ADDR_CTRL && s_q.wstrb[0] && !sync_busy
        |=> s_q.ctrl[CTRL_ENABLE] == $past(s_q.wdata[CTRL_ENABLE]) && $stable(s_q.osc_en))
        else $error("enable readback or delay wrong");
    a_cycle_difference_open_hold: assert property (
        !s_q.ctrl[CTRL_MODE] |=> $stable(s_q.cycle_difference))
        else $error("cycle difference moved in open loop");
    a_cycle_difference_value: assert property (
        s_q.run && s_q.ctrl[CTRL_MODE] && ref_tick
        |=> s_q.cycle_difference == $past(s_q.mul[15:0]) - $past(s_q.cnt) - 16'($past(out_tick)))
        else $error("cycle difference wrong");
    a_coarse_step: assert property (
        !wr_go |=> ((s_q.coarse > $past(s_q.coarse)) ? s_q.coarse - $past(s_q.coarse)
            : $past(s_q.coarse) - s_q.coarse) <= $past(s_q.mul[MUL_COARSE_STEP_LSB +: 6]))
        else $error("coarse step too large");
    a_fine_step: assert property (
        !wr_go |=> ((s_q.fine > $past(s_q.fine)) ? s_q.fine - $past(s_q.fine)
            : $past(s_q.fine) - s_q.fine) <= $past(s_q.mul[MUL_FINE_STEP_LSB +: 10]))
        else $error("fine step too large");
    a_mul_clears_lock: assert property (
        wr_go && s_q.waddr == ADDR_MUL
        |=> s_q.fine == FINE_MID && (s_q.phase == PH_COARSE || s_q.phase == PH_IDLE))
        else $error("multiplier write kept locks");
    a_value_read_request_snap: assert property (
        s_q.rd_pend && sync_done
        |=> s_q.snap == $past({s_q.cycle_difference, s_q.coarse, s_q.fine}) && !s_q.rd_pend)
        else $error("read request did not refresh value");
    a_wake_lose: assert property (
        wake_stopped && s_q.ctrl[CTRL_LOSE_LOCK] && s_q.phase == PH_LOCKED
        |=> s_q.phase != PH_LOCKED && s_q.stat[EV_LOST])
        else $error("locks kept after wake");
    a_stable_freeze: assert property (
        s_q.phase == PH_LOCKED && s_q.ctrl[CTRL_STABLE] && !wr_go |=> $stable(s_q.fine))
        else $error("fine moved in stable mode");
    a_run_on_demand: assert property (
        s_q.osc_en && s_q.ctrl[CTRL_ON_REQUEST] && !clk_request |=> !osc_run)
        else $error("oscillator ran without request");
endmodule // fllc_loop_regs
`default_nettype wire

// ### testbench/fllc_ref_model.sv
`timescale 1ns/1ps
`default_nettype none
// Reference and output clock stand-in. A reference period is 16 cycles.
// Output pulses fall on odd cycles only, so a period boundary never meets one.
module fllc_ref_model (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Oscillator state.
    input wire logic osc_run,
    // Measurement pulses.
    output logic ref_tick,
    output logic out_tick
);
    logic [3:0] phase_q;
    // The reference runs free whether the loop runs or not.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase_q <= 4'h0;
        end else begin
            phase_q <= phase_q + 4'h1;
        end
    end
    assign ref_tick = (phase_q == 4'he);
    // A stopped oscillator gives no pulses; a running one gives eight per period.
    assign out_tick = osc_run & phase_q[0];
endmodule // fllc_ref_model
`default_nettype wire

// ### testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import fllc_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic clk_request = 1'b0, wake_stopped = 1'b0;
    wire logic awready, wready, bvalid, arready, rvalid, ref_tick, out_tick, osc_run;
    wire logic closed_loop, quick_lock_disable, chill_cycle_disable, loop_ready_flag, irq;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [5:0] coarse_cal;
    wire logic [9:0] fine_cal;
    int n_errors = 0;
    int n_compared = 0;
    logic [31:0] rd;
    logic [1:0] rsp;

    fllc_loop_regs i_fllc_loop_regs (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
        .rresp(rresp), .ref_tick(ref_tick), .out_tick(out_tick), .clk_request(clk_request),
        .wake_stopped(wake_stopped), .osc_run(osc_run), .closed_loop(closed_loop),
        .coarse_cal(coarse_cal), .fine_cal(fine_cal), .quick_lock_disable(quick_lock_disable),
        .chill_cycle_disable(chill_cycle_disable), .loop_ready_flag(loop_ready_flag), .irq(irq));
    fllc_ref_model i_fllc_ref_model (.aclk(aclk), .aresetn(aresetn), .osc_run(osc_run),
        .ref_tick(ref_tick), .out_tick(out_tick));

    // Free-running 125 MHz clock.
    always #4 aclk = ~aclk;

    // Single place where the run ends.
    task automatic conclude;
        if (n_errors == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // Address and data are offered together; each is dropped when taken.
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        axw(a, d, rsp);
        chk(32'(rsp), 32'(RESP_OK));
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        axr(a, rd, rsp);
        chk(rd, exp);
    endtask

    // Waits out a settling write; two more edges let the oscillator follow.
    task automatic wait_ready;
        for (int i = 0; i < 40 && loop_ready_flag !== 1'b1; i++) @(posedge aclk);
        chk(32'(loop_ready_flag), 32'h1);
        repeat (2) @(posedge aclk);
    endtask

    task automatic t_reset;
        rdchk(ADDR_CTRL, 32'h00000080);
        rdchk(ADDR_VAL, 32'h0);
        rdchk(ADDR_MUL, 32'h0);
    endtask

    task automatic t_enable;
        wr(ADDR_CTRL, 32'h00000302);
        chk(32'(loop_ready_flag), 32'h0);
        chk(32'(osc_run), 32'h0);
        rdchk(ADDR_CTRL, 32'h00000302);
        wait_ready();
        chk(32'(osc_run), 32'h1);
        chk(32'({quick_lock_disable, chill_cycle_disable}), 32'h3);
        chk(32'(closed_loop), 32'h0);
    endtask

    task automatic t_demand;
        wr(ADDR_CTRL, 32'h00000082);
        wait_ready();
        chk(32'(osc_run), 32'h0);
        clk_request <= 1'b1;
        repeat (3) @(posedge aclk);
        chk(32'(osc_run), 32'h1);
    endtask

    // Open loop: calibration is writable, and the multiplier recentres fine.
    task automatic t_open;
        wr(ADDR_VAL, 32'h00002c55);
        repeat (2) @(posedge aclk);
        chk(32'({coarse_cal, fine_cal}), 32'h2c55);
        rdchk(ADDR_VAL, 32'h00002c55);
        wr(ADDR_MUL, 32'h00000010);
        wait_ready();
        chk(32'({coarse_cal, fine_cal}), 32'h2e00);
        rdchk(ADDR_MUL, 32'h00000010);
    endtask

    // Zero step limits pin the calibration, so 16 minus 8 counted is the difference.
    task automatic t_closed;
        wr(ADDR_CTRL, 32'h00000086);
        wait_ready();
        chk(32'(closed_loop), 32'h1);
        repeat (100) @(posedge aclk);
        chk(32'({coarse_cal, fine_cal}), 32'h2e00);
        wr(ADDR_VAL, 32'h0);
        chk(32'({coarse_cal, fine_cal}), 32'h2e00);
        wr(ADDR_SYNC, 32'h00000080);
        wait_ready();
        rdchk(ADDR_VAL, 32'h00082e00);
        rdchk(ADDR_SYNC, 32'h0);
    endtask

    task automatic t_irq;
        wr(ADDR_MASK, 32'h1);
        repeat (2) @(posedge aclk);
        chk(32'(irq), 32'h1);
        wr(ADDR_STAT, 32'hf);
        repeat (2) @(posedge aclk);
        chk(32'(irq), 32'h0);
        wr(ADDR_MASK, 32'h0);
        wr(ADDR_CTRL, 32'h00000086);
        wait_ready();
        chk(32'(irq), 32'h0);
        wr(ADDR_MASK, 32'h1);
        repeat (2) @(posedge aclk);
        chk(32'(irq), 32'h1);
    endtask

    // A one-step limit lets coarse climb by one per unchilled period at most.
    task automatic t_step;
        wr(ADDR_MUL, 32'h04010010);
        repeat (40) @(posedge aclk);
        chk(32'(coarse_cal > 6'h0b && coarse_cal <= 6'h0e), 32'h1);
        chk(32'(fine_cal), 32'h200);
    endtask

    // A stopped-clock wake loses locks only with the option set.
    task automatic t_wake;
        wr(ADDR_STAT, 32'hf);
        wake_stopped <= 1'b1;
        @(posedge aclk);
        wake_stopped <= 1'b0;
        rdchk(ADDR_STAT, 32'h00000010);
        wr(ADDR_CTRL, 32'h00000096);
        wait_ready();
        wr(ADDR_STAT, 32'hf);
        wake_stopped <= 1'b1;
        @(posedge aclk);
        wake_stopped <= 1'b0;
        rdchk(ADDR_STAT, 32'h00000018);
    endtask

    task automatic t_unmapped;
        axw(8'h00, 32'h1, rsp);
        chk(32'(rsp), 32'(RESP_SLVERR));
        axr(8'h34, rd, rsp);
        chk(32'(rsp), 32'(RESP_SLVERR));
    endtask

    // Main sequence after 12 cycles of reset.
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_enable();
        t_demand();
        t_open();
        t_closed();
        t_irq();
        t_step();
        t_wake();
        t_unmapped();
        conclude();
    end

    // The whole sequence needs well under 2000 cycles; a hang ends here.
    initial begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        conclude();
    end
endmodule // testbench
`default_nettype wire
